// >>> rtl/stpf_framer.v
// What this block does
// - Packets are 440 bytes, 217 data words
// - One housekeeping slot per polling cycle when powered
// - Unit allocation clamped to total per cycle
// - Science output limited to written allocation minus one
// - Overflow switches primary to secondary format
// - Overflow in secondary enables grey filtering
// - Grey filter number 0 to 31
// - 40-bit time stamp from word 0 bit 8
// - Second word LSB counts seconds
// - Lowest three time stamp bits are zero
// - Primary header version, APID, sequence, length
// - Word 0 holds type, subtype, time top
// - APID chosen per instrument unit
// - Event is XY word plus energy/delta word
// - Long delta flagged 255 plus extension word
// - Gap over 8 s writes FFFF, timing lost
// - Quiet polling cycle flushes partial packet
// - Full imaging data field word layout
// - At most 105 records, count reported
// - Grey change mid-packet inserts zero-XY marker event
// - Markers counted in event count
`timescale 1ns/1ps
`include "stpf_consts.vh"
module stpf_framer #(
    parameter EVT_WORDS = `STPF_EVT_WORDS
) (
    input wire sys_clk_in,
    input wire rst_in,
    input wire ce_in,
    input wire [4:0] avs_address_in,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire [31:0] avs_writedata_in,
    input wire [3:0] avs_byteenable_in,
    output reg [31:0] avs_readdata_out,
    output reg avs_waitrequest_out,
    input wire evt_valid_in,
    input wire [7:0] evt_x_in,
    input wire [7:0] evt_y_in,
    input wire [7:0] evt_energy_in,
    output reg evt_ready_out,
    input wire [39:0] onboard_time_stamp_in,
    input wire hk_poll_in,
    input wire dpu_power_in,
    output reg hk_slot_out,
    output reg [7:0] tm_data_out,
    output reg tm_valid_out,
    output reg tm_sop_out,
    output reg tm_eop_out,
    input wire tm_ready_in,
    output reg grey_en_out,
    output reg [4:0] grey_num_out,
    output reg [1:0] fmt_sel_out
);
    // ****************************************
    // States
    // ****************************************
    localparam S_COLLECT = 3'h0;
    localparam S_WR_A = 3'h1;
    localparam S_WR_B = 3'h2;
    localparam S_WR_C = 3'h3;
    localparam S_WAIT = 3'h4;
    localparam S_TX = 3'h5;

    reg [15:0] mem [0:EVT_WORDS-1];
    reg [2:0] st_r;
    reg [7:0] ptr_r;
    reg [6:0] count_r;
    reg [39:0] ts_first_r;
    reg [4:0] grey_first_r;
    reg [36:0] prev_tick_r;
    reg lost_r;
    reg [15:0] rec_a_r;
    reg [15:0] rec_b_r;
    reg [15:0] rec_c_r;
    reg rec_ext_r;
    reg mark_pend_r;
    reg evt_seen_r;
    reg flush_r;
    reg ovf_seen_r;
    reg [8:0] tx_idx_r;
    reg [13:0] seq_r;
    reg [4:0] sent_r;
    reg enable_r;
    reg unit_r;
    reg [1:0] pri_fmt_r;
    reg [1:0] sec_fmt_r;
    reg [4:0] alloc_r;
    reg sec_act_r;
    reg restart_r;
    reg [5:0] grey_prev_r;
    reg hk_s1_r;
    reg hk_s2_r;
    reg hk_s3_r;
    wire hk_tick;
    wire [36:0] now_tick;
    wire [36:0] delta;
    wire [7:0] d_byte;
    wire [15:0] d_ext;
    wire d_need;
    wire d_lost;
    wire room;
    wire [4:0] budget;
    wire req;
    wire [7:0] word_idx;
    wire [15:0] tx_word;
    wire mark_go;
    wire evt_go;

    assign hk_tick = hk_s2_r & ~hk_s3_r;
    assign now_tick = onboard_time_stamp_in[39:3];
    assign delta = (count_r == 7'h00) ? 37'h0 :
        now_tick - prev_tick_r;
    assign room = (ptr_r <= `STPF_PTR_ROOM) &&
        (count_r < `STPF_EVT_MAX);
    assign budget = (dpu_power_in && alloc_r != 5'h00) ?
        alloc_r - 5'h01 : 5'h00;
    assign req = (avs_read_in | avs_write_in) & avs_waitrequest_out;
    assign word_idx = tx_idx_r[8:1];
    assign mark_go = (st_r == S_COLLECT) && mark_pend_r &&
        (count_r != 7'h00) && room;
    assign evt_go = (st_r == S_COLLECT) && evt_valid_in &&
        evt_ready_out;

    stpf_delta_enc u_delta (
        .delta_in(delta),
        .lost_in(lost_r),
        .byte_out(d_byte),
        .ext_out(d_ext),
        .ext_need_out(d_need),
        .lost_out(d_lost)
    );

    // ****************************************
    // Packet word lookup
    // ****************************************
    function [15:0] pkt_word;
        input [7:0] idx;
        reg [7:0] off;
        begin
            off = idx - `STPF_W_EVT0;
            pkt_word = 16'h0000;
            case (idx)
                8'h00: pkt_word = {`STPF_VERSION, `STPF_PTYPE,
                    `STPF_HFLAG, unit_r ? `STPF_APID_U2 :
                    `STPF_APID_U1};
                8'h01: pkt_word = {`STPF_SEQFLAGS, seq_r};
                8'h02: pkt_word = `STPF_PKT_LEN;
                `STPF_W_TS_HI: pkt_word = {`STPF_TYPE_SUB,
                    ts_first_r[39:32]};
                `STPF_W_TS_MID: pkt_word = ts_first_r[31:16];
                `STPF_W_TS_LO: pkt_word = {ts_first_r[15:3],
                    `STPF_SPARE};
                `STPF_W_COUNT: pkt_word = {9'h000, count_r};
                `STPF_W_GREY: pkt_word = {11'h000, grey_first_r};
                default: begin
                    if (idx >= `STPF_W_EVT0 && idx < `STPF_W_EVT_END &&
                        off < ptr_r) begin
                        pkt_word = mem[off];
                    end
                end
            endcase
        end
    endfunction

    assign tx_word = pkt_word(word_idx);

    // ****************************************
    // Polling cycle synchroniser
    // ****************************************
    always @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            hk_s1_r <= 1'b0;
            hk_s2_r <= 1'b0;
            hk_s3_r <= 1'b0;
        end else if (ce_in) begin
            hk_s1_r <= hk_poll_in;
            hk_s2_r <= hk_s1_r;
            hk_s3_r <= hk_s2_r;
        end
    end

    // ****************************************
    // Register bus
    // ****************************************
    always @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            avs_waitrequest_out <= 1'b1;
            avs_readdata_out <= 32'h00000000;
            enable_r <= 1'b0;
            unit_r <= 1'b0;
            pri_fmt_r <= 2'h0;
            sec_fmt_r <= 2'h0;
            alloc_r <= `STPF_ALLOC_RST;
            restart_r <= 1'b0;
        end else if (ce_in) begin
            restart_r <= 1'b0;
            avs_waitrequest_out <= ~req;
            if (req && avs_read_in) begin
                avs_readdata_out <= 32'h00000000;
                if (avs_address_in[1:0] == 2'h0) begin
                    case (avs_address_in[4:2])
                        `STPF_REG_CTRL: avs_readdata_out <= {24'h000000,
                            sec_fmt_r, pri_fmt_r, 2'h0, unit_r,
                            enable_r};
                        `STPF_REG_ALLOC: avs_readdata_out <=
                            {27'h0000000, alloc_r};
                        `STPF_REG_STATUS: avs_readdata_out <= {6'h00,
                            st_r == S_WAIT, lost_r, 1'b0, count_r,
                            3'h0, grey_num_out, 6'h00, grey_en_out,
                            sec_act_r};
                        `STPF_REG_SEQ: avs_readdata_out <= {11'h000,
                            sent_r, 2'h0, seq_r};
                        default: avs_readdata_out <= 32'h00000000;
                    endcase
                end
            end
            if (!avs_waitrequest_out && avs_write_in &&
                avs_address_in[1:0] == 2'h0) begin
                if (avs_address_in[4:2] == `STPF_REG_CTRL) begin
                    if (avs_byteenable_in[0]) begin
                        enable_r <= avs_writedata_in[0];
                        unit_r <= avs_writedata_in[1];
                        pri_fmt_r <= avs_writedata_in[5:4];
                        sec_fmt_r <= avs_writedata_in[7:6];
                    end
                    if (avs_byteenable_in[1]) begin
                        restart_r <= avs_writedata_in[8];
                    end
                end
                if (avs_address_in[4:2] == `STPF_REG_ALLOC &&
                    avs_byteenable_in[0]) begin
                    alloc_r <= (avs_writedata_in[7:0] >
                        {3'h0, `STPF_ALLOC_MAX}) ? `STPF_ALLOC_MAX :
                        avs_writedata_in[4:0];
                end
            end
        end
    end

    // ****************************************
    // Format and grey filter control
    // ****************************************
    always @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            sec_act_r <= 1'b0;
            grey_en_out <= 1'b0;
            grey_num_out <= `STPF_GREY_MAX;
            fmt_sel_out <= 2'h0;
            hk_slot_out <= 1'b0;
            ovf_seen_r <= 1'b0;
        end else if (ce_in) begin
            fmt_sel_out <= sec_act_r ? sec_fmt_r : pri_fmt_r;
            hk_slot_out <= hk_tick & dpu_power_in;
            ovf_seen_r <= (ovf_seen_r & ~hk_tick) |
                (evt_valid_in & (st_r == S_WAIT));
            if (restart_r) begin
                sec_act_r <= 1'b0;
                grey_en_out <= 1'b0;
                grey_num_out <= `STPF_GREY_MAX;
            end else if (hk_tick && ovf_seen_r) begin
                if (!sec_act_r) begin
                    sec_act_r <= 1'b1;
                end else if (!grey_en_out) begin
                    grey_en_out <= 1'b1;
                    grey_num_out <= `STPF_GREY_FIRST;
                end else if (grey_num_out != 5'h00) begin
                    grey_num_out <= grey_num_out - 5'h01;
                end
            end
        end
    end

    // ****************************************
    // Event collection and packet output
    // ****************************************
    always @(posedge sys_clk_in) begin
        if (ce_in && (st_r == S_WR_A || st_r == S_WR_B ||
            st_r == S_WR_C)) begin
            mem[ptr_r] <= (st_r == S_WR_A) ? rec_a_r :
                (st_r == S_WR_B) ? rec_b_r : rec_c_r;
        end
    end

    always @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_r <= S_COLLECT;
            ptr_r <= 8'h00;
            count_r <= 7'h00;
            ts_first_r <= 40'h0000000000;
            grey_first_r <= 5'h00;
            prev_tick_r <= 37'h0;
            lost_r <= 1'b0;
            rec_a_r <= 16'h0000;
            rec_b_r <= 16'h0000;
            rec_c_r <= 16'h0000;
            rec_ext_r <= 1'b0;
            mark_pend_r <= 1'b0;
            evt_seen_r <= 1'b0;
            flush_r <= 1'b0;
            tx_idx_r <= 9'h000;
            seq_r <= 14'h0000;
            sent_r <= 5'h00;
            grey_prev_r <= {1'b0, `STPF_GREY_MAX};
            evt_ready_out <= 1'b0;
            tm_data_out <= 8'h00;
            tm_valid_out <= 1'b0;
            tm_sop_out <= 1'b0;
            tm_eop_out <= 1'b0;
        end else if (ce_in) begin
            evt_ready_out <= 1'b0;
            grey_prev_r <= {grey_en_out, grey_num_out};
            // Hardware set wins over the clear
            evt_seen_r <= evt_go | (evt_seen_r & ~hk_tick);
            if (hk_tick) begin
                sent_r <= 5'h00;
                if (!evt_seen_r && count_r != 7'h00 &&
                    st_r != S_TX && st_r != S_WAIT) begin
                    flush_r <= 1'b1;
                end
            end
            if ({grey_en_out, grey_num_out} != grey_prev_r) begin
                mark_pend_r <= 1'b1;
            end else if (mark_go || (evt_go && count_r == 7'h00)) begin
                mark_pend_r <= 1'b0;
            end
            case (st_r)
                S_COLLECT: begin
                    if (mark_go) begin
                        rec_a_r <= `STPF_MARK_XY;
                        rec_b_r <= {3'h0, grey_num_out, d_byte};
                        rec_c_r <= d_ext;
                        rec_ext_r <= d_need;
                        lost_r <= d_lost;
                        prev_tick_r <= now_tick;
                        count_r <= count_r + 7'h01;
                        st_r <= S_WR_A;
                    end else if (evt_go) begin
                        if (count_r == 7'h00) begin
                            ts_first_r <= onboard_time_stamp_in;
                            grey_first_r <= grey_num_out;
                        end
                        rec_a_r <= {evt_x_in, evt_y_in};
                        rec_b_r <= {evt_energy_in, d_byte};
                        rec_c_r <= d_ext;
                        rec_ext_r <= d_need;
                        lost_r <= d_lost;
                        prev_tick_r <= now_tick;
                        count_r <= count_r + 7'h01;
                        st_r <= S_WR_A;
                    end else if (count_r != 7'h00 && (!room || flush_r)) begin
                        st_r <= S_WAIT;
                    end else if (room && !(mark_pend_r &&
                        count_r != 7'h00)) begin
                        evt_ready_out <= 1'b1;
                    end
                end
                S_WR_A: begin
                    ptr_r <= ptr_r + 8'h01;
                    st_r <= S_WR_B;
                end
                S_WR_B: begin
                    ptr_r <= ptr_r + 8'h01;
                    st_r <= rec_ext_r ? S_WR_C : S_COLLECT;
                end
                S_WR_C: begin
                    ptr_r <= ptr_r + 8'h01;
                    st_r <= S_COLLECT;
                end
                S_WAIT: begin
                    flush_r <= 1'b0;
                    if (enable_r && sent_r < budget && !hk_tick) begin
                        sent_r <= sent_r + 5'h01;
                        tx_idx_r <= 9'h000;
                        st_r <= S_TX;
                    end
                end
                S_TX: begin
                    if (!tm_valid_out || tm_ready_in) begin
                        if (tx_idx_r == `STPF_PKT_BYTES) begin
                            tm_valid_out <= 1'b0;
                            tm_sop_out <= 1'b0;
                            tm_eop_out <= 1'b0;
                            seq_r <= seq_r + 14'h0001;
                            ptr_r <= 8'h00;
                            count_r <= 7'h00;
                            lost_r <= 1'b0;
                            st_r <= S_COLLECT;
                        end else begin
                            tm_valid_out <= 1'b1;
                            tm_data_out <= tx_idx_r[0] ? tx_word[7:0] :
                                tx_word[15:8];
                            tm_sop_out <= (tx_idx_r == 9'h000);
                            tm_eop_out <= (tx_idx_r == `STPF_PKT_LAST);
                            tx_idx_r <= tx_idx_r + 9'h001;
                        end
                    end
                end
                default: st_r <= S_COLLECT;
            endcase
        end
    end
endmodule

// >>> rtl/stpf_consts.vh
`ifndef STPF_CONSTS_VH
`define STPF_CONSTS_VH
// ****************************************
// Packet geometry
// ****************************************
`define STPF_PKT_BYTES 9'd440
`define STPF_PKT_LAST 9'd439
`define STPF_PKT_LEN 16'h01B1
`define STPF_W_TS_HI 8'd3
`define STPF_W_TS_MID 8'd4
`define STPF_W_TS_LO 8'd5
`define STPF_W_COUNT 8'd6
`define STPF_W_GREY 8'd7
`define STPF_W_EVT0 8'd8
`define STPF_W_EVT_END 8'd219
`define STPF_EVT_WORDS 211
`define STPF_PTR_ROOM 8'd208
`define STPF_EVT_MAX 7'd105
// ****************************************
// Header fields
// ****************************************
`define STPF_VERSION 3'h0
`define STPF_PTYPE 1'h0
`define STPF_HFLAG 1'h1
`define STPF_SEQFLAGS 2'h3
`define STPF_APID_U1 11'h648
`define STPF_APID_U2 11'h6C8
`define STPF_TYPE_SUB 8'h08
`define STPF_SPARE 3'h0
// ****************************************
// Event coding
// ****************************************
`define STPF_DELTA_FLAG 8'hFF
`define STPF_DELTA_LOST 16'hFFFF
`define STPF_DELTA_EXT 37'h00000000FF
`define STPF_DELTA_BIG 37'h000000FFFF
`define STPF_MARK_XY 16'h0000
// ****************************************
// Grey filter and allocation
// ****************************************
`define STPF_GREY_MAX 5'h1F
`define STPF_GREY_FIRST 5'h1E
`define STPF_ALLOC_MAX 5'h12
`define STPF_ALLOC_RST 5'h09
// ****************************************
// Register map (word index of byte address)
// ****************************************
`define STPF_REG_CTRL 3'h0
`define STPF_REG_ALLOC 3'h1
`define STPF_REG_STATUS 3'h2
`define STPF_REG_SEQ 3'h3
`define STPF_CTRL_RST 8'h01
`endif

// >>> rtl/stpf_delta_enc.v
`timescale 1ns/1ps
`include "stpf_consts.vh"
module stpf_delta_enc (
    input wire [36:0] delta_in,
    input wire lost_in,
    output reg [7:0] byte_out,
    output reg [15:0] ext_out,
    output reg ext_need_out,
    output reg lost_out
);
    always @* begin
        byte_out = delta_in[7:0];
        ext_out = delta_in[15:0];
        ext_need_out = 1'b0;
        lost_out = lost_in;
        if (lost_in || delta_in >= `STPF_DELTA_BIG) begin
            byte_out = `STPF_DELTA_FLAG;
            ext_out = `STPF_DELTA_LOST;
            ext_need_out = 1'b1;
            lost_out = 1'b1;
        end else if (delta_in >= `STPF_DELTA_EXT) begin
            byte_out = `STPF_DELTA_FLAG;
            ext_need_out = 1'b1;
        end
    end
endmodule

// >>> verif/stpf_checker.sv
`timescale 1ns/1ps
module stpf_checker (
    input wire sys_clk_in,
    input wire rst_in,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire avs_waitrequest_out,
    input wire evt_valid_in,
    input wire evt_ready_out,
    input wire dpu_power_in,
    input wire hk_slot_out,
    input wire [7:0] tm_data_out,
    input wire tm_valid_out,
    input wire tm_sop_out,
    input wire tm_eop_out,
    input wire tm_ready_in
);
    // ****************************************
    // Byte position in the packet
    // ****************************************
    logic [8:0] pos_r;
    wire v = tm_valid_out;
    always @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            pos_r <= 9'h000;
        end else if (v && tm_ready_in) begin
            pos_r <= tm_eop_out ? 9'h000 : pos_r + 9'h001;
        end
    end
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (rst_in);
    chk_bus_answer: assert property ((avs_read_in || avs_write_in)
        && avs_waitrequest_out |=> !avs_waitrequest_out)
        else $error("bus request not answered");
    chk_bus_single: assert property (!avs_waitrequest_out
        |=> avs_waitrequest_out) else $error("bus answer too long");
    chk_sop_byte: assert property (v && tm_sop_out |->
        pos_r == 9'h000 && tm_data_out == 8'h0E) else $error("bad sop");
    chk_eop_pos: assert property (v && tm_eop_out |->
        pos_r == 9'h1B7) else $error("bad eop position");
    chk_len_field: assert property (v && pos_r == 9'h005 |->
        tm_data_out == 8'hB1) else $error("bad length field");
    chk_type_sub: assert property (v && pos_r == 9'h006 |->
        tm_data_out == 8'h08) else $error("bad type byte");
    chk_spare_zero: assert property (v && pos_r == 9'h00B |->
        tm_data_out[2:0] == 3'h0) else $error("spare bits set");
    chk_count_max: assert property (v && pos_r == 9'h00D |->
        tm_data_out <= 8'h69) else $error("event count too big");
    chk_crc_zero: assert property (v && pos_r >= 9'h1B6 |->
        tm_data_out == 8'h00) else $error("checksum not zero");
    chk_tm_hold: assert property (v && !tm_ready_in |=>
        v && $stable(tm_data_out)) else $error("byte not held");
    chk_evt_gap: assert property (evt_valid_in && evt_ready_out
        |=> !evt_ready_out [*3]) else $error("event spacing short");
    chk_hk_pulse: assert property (hk_slot_out |->
        $past(dpu_power_in) ##1 !hk_slot_out) else $error("bad slot");
endmodule
bind stpf_framer stpf_checker u_chk (.*);

// >>> verif/stpf_dhs_model.sv
`timescale 1ns/1ps
module stpf_dhs_model (
    input wire sys_clk_in,
    input wire [7:0] tm_data_in,
    input wire tm_valid_in,
    input wire tm_sop_in,
    input wire tm_eop_in,
    input wire hk_slot_in,
    output logic tm_ready_out,
    output logic hk_poll_out
);
    // ****************************************
    // Packet sink and polling source
    // ****************************************
    logic [7:0] pkt [0:439];
    logic slow = 1'b1;
    int idx, plen, npkt, nslot, pcyc, pmax;
    initial begin
        tm_ready_out = 1'b0;
        hk_poll_out = 1'b0;
    end
    always @(posedge sys_clk_in) begin
        tm_ready_out <= slow ? ~tm_ready_out : 1'b1;
        if (hk_slot_in === 1'b1) begin
            nslot++;
        end
        if (tm_valid_in && tm_ready_out) begin
            idx = tm_sop_in ? 0 : idx;
            pkt[idx] = tm_data_in;
            idx++;
            if (tm_eop_in) begin
                plen = idx;
                npkt++;
                pcyc++;
                pmax = (pcyc > pmax) ? pcyc : pmax;
            end
        end
    end
    task poll();
        @(posedge sys_clk_in);
        hk_poll_out <= 1'b1;
        pcyc = 0;
        repeat (4) @(posedge sys_clk_in);
        hk_poll_out <= 1'b0;
        repeat (40) @(posedge sys_clk_in);
    endtask
endmodule

// >>> verif/stpf_framer_tb.sv
`timescale 1ns/1ps
module stpf_framer_tb;
    logic clk, rst, ce_in, avs_read_in, avs_write_in, avs_waitrequest_out;
    logic [4:0] avs_address_in, grey_num_out;
    logic [31:0] avs_writedata_in, avs_readdata_out, rq;
    logic [3:0] avs_byteenable_in;
    logic evt_valid_in, evt_ready_out, hk_poll_in, dpu_power_in;
    logic [7:0] evt_x_in, evt_y_in, evt_energy_in, tm_data_out;
    logic [39:0] onboard_time_stamp_in;
    logic hk_slot_out, tm_valid_out, tm_sop_out, tm_eop_out, tm_ready_in;
    logic grey_en_out;
    logic [1:0] fmt_sel_out;
    int miscompares, n_checks;
    always #50 clk = ~clk;
    stpf_framer DUT (.sys_clk_in(clk), .rst_in(rst), .*);
    stpf_dhs_model DHS (.sys_clk_in(clk), .tm_data_in(tm_data_out),
        .tm_valid_in(tm_valid_out), .tm_sop_in(tm_sop_out),
        .tm_eop_in(tm_eop_out), .hk_slot_in(hk_slot_out),
        .tm_ready_out(tm_ready_in), .hk_poll_out(hk_poll_in));
    // ****************************************
    // Shared tasks
    // ****************************************
    task check(input logic [39:0] seen, input logic [39:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task close_out();
        if (miscompares == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task give_up();
        miscompares++;
        close_out();
    endtask
    task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        avs_address_in <= a;
        avs_writedata_in <= d;
        avs_write_in <= w;
        avs_read_in <= ~w;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest_out !== 1'b0 && n < 50);
        rq = avs_readdata_out;
        avs_read_in <= 1'b0;
        avs_write_in <= 1'b0;
        if (n >= 50) give_up();
    endtask
    task ev(input logic [7:0] x, y, e, input logic [39:0] t);
        int n;
        @(posedge clk);
        evt_valid_in <= 1'b1;
        {evt_x_in, evt_y_in, evt_energy_in} <= {x, y, e};
        onboard_time_stamp_in <= t;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (evt_ready_out !== 1'b1 && n < 900);
        evt_valid_in <= 1'b0;
        if (n >= 900) give_up();
    endtask
    task flush(input int np);
        int n;
        repeat (3) DHS.poll();
        n = 0;
        while (DHS.npkt < np && n < 3000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 3000) give_up();
        check(DHS.npkt, np);
    endtask
    function automatic logic [15:0] wd(input int i);
        return {DHS.pkt[2*i], DHS.pkt[2*i+1]};
    endfunction
    // ****************************************
    // Scenarios
    // ****************************************
    task t_regs();
        bus(1'b0, 5'h04, 32'h0);
        check(rq, 32'h9);
        bus(1'b0, 5'h00, 32'h0);
        check(rq, 32'h0);
        bus(1'b1, 5'h04, 32'h1F);
        bus(1'b0, 5'h04, 32'h0);
        check(rq, 32'h12);
        bus(1'b0, 5'h10, 32'h0);
        check(rq, 32'h0);
        bus(1'b1, 5'h04, 32'h3);
        bus(1'b1, 5'h00, 32'h1);
    endtask
    task t_power();
        int s;
        s = DHS.nslot;
        dpu_power_in <= 1'b0;
        repeat (2) DHS.poll();
        check(DHS.nslot, s);
        dpu_power_in <= 1'b1;
        DHS.poll();
        check(DHS.nslot, s + 1);
    endtask
    task t_frame();
        ev(8'h12, 8'h34, 8'h56, 40'h12_3456_7887);
        ev(8'h21, 8'h43, 8'h65, 40'h12_3456_78AF);
        ev(8'hA1, 8'hB2, 8'hC3, 40'h12_3456_820F);
        flush(1);
        check(DHS.plen, 440);
        check(wd(0), 16'h0E48);
        check(wd(1), 16'hC000);
        check(wd(2), 16'h01B1);
        check(wd(3), 16'h0812);
        check(wd(4), 16'h3456);
        check(wd(5), 16'h7880);
        check(wd(6), 16'h0003);
        check(wd(7), 16'h001F);
        check(wd(8), 16'h1234);
        check(wd(9), 16'h5600);
        check(wd(11), 16'h6505);
        check(wd(13), 16'hC3FF);
        check(wd(14), 16'h012C);
        check(wd(15), 16'h0000);
        check(wd(219), 16'h0000);
    endtask
    task t_unit2();
        DHS.slow = 1'b0;
        bus(1'b1, 5'h00, 32'h3);
        ev(8'h05, 8'h06, 8'h07, 40'h20_0000_0000);
        ev(8'h08, 8'h09, 8'h0A, 40'h20_0008_0000);
        flush(2);
        check(wd(0), 16'h0EC8);
        check(wd(1), 16'hC001);
        check(wd(3), 16'h0820);
        check(wd(6), 16'h0002);
        check(wd(9), 16'h0700);
        check(wd(11), 16'h0AFF);
        check(wd(12), 16'hFFFF);
        check(DHS.pmax <= 2, 1'b1);
    endtask
    task t_grey();
        bus(1'b1, 5'h00, 32'h90);
        repeat (3) @(negedge clk);
        check(fmt_sel_out, 2'h1);
        ev(8'h01, 8'h02, 8'h03, 40'h30_0000_0000);
        repeat (3) DHS.poll();
        @(posedge clk);
        evt_valid_in <= 1'b1;
        DHS.poll();
        check({grey_en_out, fmt_sel_out}, 3'h2);
        DHS.poll();
        check({grey_en_out, grey_num_out}, 6'h3E);
        DHS.poll();
        check(grey_num_out, 5'h1D);
        evt_valid_in <= 1'b0;
        bus(1'b1, 5'h00, 32'h190);
        repeat (3) @(negedge clk);
        check({grey_en_out, grey_num_out, fmt_sel_out}, 8'h7D);
        check(DHS.npkt, 2);
    endtask
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        ce_in = 1'b1;
        avs_byteenable_in = 4'hF;
        {avs_read_in, avs_write_in, evt_valid_in} = 3'h0;
        avs_address_in = 5'h00;
        avs_writedata_in = 32'h0;
        {evt_x_in, evt_y_in, evt_energy_in} = 24'h0;
        onboard_time_stamp_in = 40'h0;
        dpu_power_in = 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_power();
        t_frame();
        t_unit2();
        t_grey();
        close_out();
    end
endmodule
